// [rtl/dual_supervisor_reset_gen.sv]
`timescale 1ns/1ps

module dual_supervisor_reset_gen
    import supervisor_pkg::*;
#(
    parameter logic        ACTIVE_HIGH = 1'b0,
    parameter int unsigned HOLD_COUNT  = HOLD_CYCLES
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_in_under,
    input  wire logic i_vdd_under,
    input  wire logic i_manual_reset_n,
    input  wire logic i_manual_reset_n_oe,
    output logic      o_reset,
    output logic      o_reset_active
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync1_d;
    logic       mr_pin;

    // Undriven manual pin is pulled to the inactive level
    assign mr_pin = i_manual_reset_n_oe ? i_manual_reset_n : 1'b1;

    // Stage inputs; stage one feeds stage two only
    always_comb begin
        sync1_d = {i_in_under, i_vdd_under, mr_pin};
    end

    // Causes reset to their asserting level so power-on is covered
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= {RST_SYNC_VAL, RST_SYNC_VAL, ~RST_SYNC_VAL};
            sync2_q <= {RST_SYNC_VAL, RST_SYNC_VAL, ~RST_SYNC_VAL};
        end else begin
            sync1_q <= sync1_d;
            sync2_q <= sync1_q;
        end
    end

    // ************************************************************
    // Cause filtering
    // ************************************************************
    logic in_under_f;
    logic vdd_under_f;
    logic mr_db;
    logic mr_low_raw;

    // Glitch filters delay both the assertion and the release of an undervoltage
    level_filter #(
        .LIMIT     (FILT_W'(GLITCH_CYCLES)),
        .RESET_VAL (RST_CAUSE_VAL)
    ) u_in_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_level   (sync2_q[2]),
        .o_level   (in_under_f)
    );

    level_filter #(
        .LIMIT     (FILT_W'(GLITCH_CYCLES)),
        .RESET_VAL (RST_CAUSE_VAL)
    ) u_vdd_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_level   (sync2_q[1]),
        .o_level   (vdd_under_f)
    );

    // Debounce both edges; press is also taken raw so it is immediate
    level_filter #(
        .LIMIT     (FILT_W'(DEBOUNCE_CYCLES)),
        .RESET_VAL (1'b1)
    ) u_mr_filt (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_level   (sync2_q[0]),
        .o_level   (mr_db)
    );

    // Raw low wins so a press of minimum width is never missed
    assign mr_low_raw = ~sync2_q[0];

    // ************************************************************
    // Hold counter
    // ************************************************************
    logic              cause;
    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] hold_d;
    logic              active_q;
    logic              active_d;

    // Any cause, ORed; bouncing contacts keep the debounced low
    assign cause = in_under_f | vdd_under_f | mr_low_raw | ~mr_db;

    // Count restarts on any cause; release only after a full count
    always_comb begin
        hold_d   = hold_q;
        active_d = active_q;
        if (cause) begin
            hold_d   = '0;
            active_d = 1'b1;
        end else if (active_q) begin
            if (hold_q >= HOLD_W'(HOLD_COUNT - 1)) begin
                active_d = 1'b0;
            end else begin
                hold_d = hold_q + 32'h00000001;
            end
        end
    end

    // Power-on starts with reset active and count at zero
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            hold_q   <= '0;
            active_q <= 1'b1;
        end else begin
            hold_q   <= hold_d;
            active_q <= active_d;
        end
    end

    // ************************************************************
    // Output
    // ************************************************************
    logic out_q;
    logic out_d;

    // Manual low bypasses the counter register for immediacy
    always_comb begin
        out_d = (active_d | mr_low_raw) ~^ ACTIVE_HIGH;
    end

    // Registered output, asserted under reset
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            out_q <= ACTIVE_HIGH;
        end else begin
            out_q <= out_d;
        end
    end

    assign o_reset        = out_q;
    assign o_reset_active = out_q ~^ ACTIVE_HIGH;

    // ************************************************************
    // Assertions
    // ************************************************************
    logic [HOLD_W-1:0] quiet_q;

    // Cycles since the last cause, for release timing checks
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            quiet_q <= '0;
        end else if (cause) begin
            quiet_q <= '0;
        end else if (quiet_q != 32'hFFFFFFFF) begin
            quiet_q <= quiet_q + 32'h00000001;
        end
    end

    property p_cause_asserts;
        @(posedge i_sys_clk) disable iff (i_rst)
        cause |=> o_reset_active;
    endproperty
    a_cause_asserts: assert property (p_cause_asserts)
        else $error("reset not active after a cause");

    property p_manual_immediate;
        @(posedge i_sys_clk) disable iff (i_rst)
        mr_low_raw |=> o_reset_active;
    endproperty
    a_manual_immediate: assert property (p_manual_immediate)
        else $error("manual low did not assert reset");

    property p_no_early_release;
        @(posedge i_sys_clk) disable iff (i_rst)
        $fell(o_reset_active) |-> quiet_q >= HOLD_W'(HOLD_COUNT);
    endproperty
    a_no_early_release: assert property (p_no_early_release)
        else $error("reset released before hold time");

    property p_release_on_time;
        @(posedge i_sys_clk) disable iff (i_rst)
        (quiet_q == HOLD_W'(HOLD_COUNT + 1)) |-> !o_reset_active;
    endproperty
    a_release_on_time: assert property (p_release_on_time)
        else $error("reset not released after hold time");

    property p_restart;
        @(posedge i_sys_clk) disable iff (i_rst)
        (active_q && cause) |=> hold_q == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("hold count not restarted by cause");

    property p_in_asserts;
        @(posedge i_sys_clk) disable iff (i_rst)
        in_under_f |=> o_reset_active;
    endproperty
    a_in_asserts: assert property (p_in_asserts)
        else $error("input undervoltage did not assert reset");

    property p_vdd_glitch;
        @(posedge i_sys_clk) disable iff (i_rst)
        $rose(sync2_q[1]) ##1 !sync2_q[1] |-> !vdd_under_f;
    endproperty
    a_vdd_glitch: assert property (p_vdd_glitch)
        else $error("single cycle supply dip passed filter");

    property p_polarity;
        @(posedge i_sys_clk) disable iff (i_rst)
        o_reset == (o_reset_active ~^ ACTIVE_HIGH);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("output polarity wrong");

    c_power_on_release: cover property (@(posedge i_sys_clk)
        disable iff (i_rst) $fell(o_reset_active));
    c_manual_press: cover property (@(posedge i_sys_clk)
        disable iff (i_rst) $rose(mr_low_raw) && !active_q);
    c_vdd_dip: cover property (@(posedge i_sys_clk)
        disable iff (i_rst) $rose(vdd_under_f));
    c_restart: cover property (@(posedge i_sys_clk)
        disable iff (i_rst) active_q && cause && hold_q != '0);

endmodule

// [rtl/supervisor_pkg.sv]
package supervisor_pkg;

    // ************************************************************
    // Timebase
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned HOLD_TIME_MS     = 140;
    localparam int unsigned HOLD_CYCLES      =
        (HOLD_TIME_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned MIN_PULSE_NS     = 33;
    localparam int unsigned MIN_PULSE_CYCLES =
        (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Filter and counter sizing
    // ************************************************************
    localparam int unsigned DEBOUNCE_US      = 10;
    localparam int unsigned DEBOUNCE_CYCLES  =
        (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned GLITCH_NS        = 200;
    localparam int unsigned GLITCH_CYCLES    = GLITCH_NS / CLK_PERIOD_NS;
    localparam int unsigned FILT_W           = 16;
    localparam int unsigned HOLD_W           = 32;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic        RST_CAUSE_VAL    = 1'b1;
    localparam logic        RST_SYNC_VAL     = 1'b1;

endpackage

// [rtl/level_filter.sv]
`timescale 1ns/1ps

// Level filter: the output follows the input only after the input
// has stood at a new level for LIMIT consecutive cycles.
module level_filter
    import supervisor_pkg::*;
#(
    parameter logic [FILT_W-1:0] LIMIT     = 16'h0001,
    parameter logic              RESET_VAL = 1'b1
) (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_level,
    output logic      o_level
);

    logic [FILT_W-1:0] cnt_q;
    logic [FILT_W-1:0] cnt_d;
    logic              out_q;
    logic              out_d;

    // Count cycles of disagreement; any agreement restarts the count
    always_comb begin
        cnt_d = '0;
        out_d = out_q;
        if (i_level != out_q) begin
            if (cnt_q >= LIMIT - 16'h0001) begin
                out_d = i_level;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    // Register the filtered level
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= '0;
            out_q <= RESET_VAL;
        end else begin
            cnt_q <= cnt_d;
            out_q <= out_d;
        end
    end

    assign o_level = out_q;

endmodule

// [verif/reset_sink_model.sv]
`timescale 1ns/1ps

// ************************************************************
// Processor reset input seen from the far side
// ************************************************************
// The sink takes the active-low reset level as a real processor input
// would. It counts release events, so a stray release shows up as an
// extra count.
module reset_sink_model (
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    output logic      o_in_reset,
    output int        o_releases
);
    // Polarity of the low-active variant is fixed here
    assign o_in_reset = ~i_reset_n;

    // Count each edge where the core leaves reset
    always @(posedge i_reset_n) begin
        o_releases++;
    end

    initial begin
        o_releases = 0;
    end
endmodule

// [verif/dual_supervisor_reset_gen_tb.sv]
`timescale 1ns/1ps

module dual_supervisor_reset_gen_tb;
    import supervisor_pkg::*;

    localparam int unsigned HOLD = 50;

    logic i_sys_clk = 1'b0;
    logic i_rst     = 1'b1;
    logic in_under  = 1'b0;
    logic vdd_under = 1'b0;
    logic drv       = 1'b1;
    logic oe        = 1'b0;
    logic pin;
    logic o_reset;
    logic o_reset_active;
    logic o_reset_h;
    logic in_reset;
    int   releases;
    int   err_total = 0;
    int   tests_run = 0;
    int   n;

    // Pin level: open pin floats up through the internal pull-up
    assign pin = oe ? drv : 1'b1;

    always #5 i_sys_clk = ~i_sys_clk;

    dual_supervisor_reset_gen #(.ACTIVE_HIGH(1'b0), .HOLD_COUNT(HOLD)) dut (
        .i_sys_clk          (i_sys_clk),
        .i_rst              (i_rst),
        .i_in_under         (in_under),
        .i_vdd_under        (vdd_under),
        .i_manual_reset_n   (pin),
        .i_manual_reset_n_oe(oe),
        .o_reset            (o_reset),
        .o_reset_active     (o_reset_active)
    );

    // Active-high variant on the same stimulus
    dual_supervisor_reset_gen #(.ACTIVE_HIGH(1'b1), .HOLD_COUNT(HOLD)) dut_h (
        .i_sys_clk          (i_sys_clk),
        .i_rst              (i_rst),
        .i_in_under         (in_under),
        .i_vdd_under        (vdd_under),
        .i_manual_reset_n   (pin),
        .i_manual_reset_n_oe(oe),
        .o_reset            (o_reset_h),
        .o_reset_active     ()
    );

    reset_sink_model sink (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (o_reset),
        .o_in_reset(in_reset),
        .o_releases(releases)
    );

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Bounded wait for the reset flag to reach a level
    task automatic await(input logic exp, input int lim, output int cnt);
        cnt = 0;
        while (o_reset_active !== exp && cnt < lim) begin
            @(posedge i_sys_clk);
            #1;
            cnt++;
        end
        chk(o_reset_active === exp, "reset flag did not settle");
        chk(in_reset === o_reset_active, "output polarity wrong");
        chk(o_reset_h === o_reset_active, "high variant wrong");
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge i_sys_clk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_power_on();
        await(1'b0, 2000, n);
        chk(n >= HOLD, "power-on pulse too short");
        oe <= 1'b0;
        drv <= 1'b0;
        cycles(40);
        #1;
        chk(o_reset_active === 1'b0, "open pin caused reset");
        $display("test power_on done");
    endtask

    task automatic t_manual();
        oe <= 1'b1;
        cycles(1);
        chk(o_reset_active === 1'b0, "reset before press");
        cycles(MIN_PULSE_CYCLES);
        #1;
        chk(o_reset_active === 1'b1, "press not immediate");
        // Hold the press past the debounce so the release is filtered
        cycles(DEBOUNCE_CYCLES + 10);
        drv <= 1'b1;
        cycles(20);
        drv <= 1'b0;
        cycles(2);
        drv <= 1'b1;
        cycles(1);
        #1;
        chk(o_reset_active === 1'b1, "bounce released reset");
        await(1'b0, 3000, n);
        chk(n >= HOLD + DEBOUNCE_CYCLES, "release too early");
        $display("test manual done");
    endtask

    // One- and ten-cycle glitches, real dip, then a second dip inside the countdown
    task automatic t_under(input bit sel);
        if (sel) vdd_under <= 1'b1; else in_under <= 1'b1;
        cycles(1);
        {in_under, vdd_under} <= 2'b00;
        cycles(3);
        if (sel) vdd_under <= 1'b1; else in_under <= 1'b1;
        cycles(10);
        {in_under, vdd_under} <= 2'b00;
        cycles(40);
        #1;
        chk(o_reset_active === 1'b0, "brief dip caused reset");
        if (sel) vdd_under <= 1'b1; else in_under <= 1'b1;
        await(1'b1, 30, n);
        cycles(10);
        {in_under, vdd_under} <= 2'b00;
        cycles(30);
        if (sel) vdd_under <= 1'b1; else in_under <= 1'b1;
        cycles(30);
        {in_under, vdd_under} <= 2'b00;
        cycles(1);
        await(1'b0, 300, n);
        chk(n >= HOLD, "hold not restarted");
        $display("test under %0d done", sel);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        cycles(16);
        i_rst <= 1'b0;
        #1;
        chk(o_reset_active === 1'b1, "no reset after power-on");
        t_power_on();
        t_manual();
        t_under(1'b0);
        t_under(1'b1);
        chk(releases == 4, "unexpected release count");
        print_verdict();
    end

    // Whole run needs under 6000 cycles; allow ten times that
    initial begin
        #600us;
        err_total++;
        print_verdict();
    end
endmodule
